// [hdl/bsic_pkg.sv]
// package: register map, field layout, reset values and timer constants
package bsic_pkg;
    localparam int NUM_HS = 4;
    localparam int NUM_LS = 7;
    localparam logic [9:0] ADDR_CHARGE_STATUS = 10'h1A5;
    localparam logic [9:0] ADDR_LINK_PAIR_A = 10'h1A6;
    localparam logic [9:0] ADDR_LINK_PAIR_B = 10'h1A7;
    localparam logic [15:0] RESET_LINK_PAIR = 16'h7F7F;
    localparam logic [15:0] RESET_CHARGE_STATUS = 16'h001F;
    localparam int TIMER_FIELD_LSB = 10;
    localparam int RAISED_FIELD_LSB = 5;
    localparam int OVERRIDE_BIT = 7;
    localparam int HALF_WIDTH = 8;
    // timer field steps every 0.68 ms approx; one code per tick period
    localparam real CODE_STEP_MS = 0.68;
    localparam real CLK_PERIOD_NS = 10.0;
    localparam int CODE_STEP_CYCLES = int'(CODE_STEP_MS * 1.0E6 / CLK_PERIOD_NS);
    localparam logic [5:0] TIMER_IDLE = 6'h00;
    localparam logic [5:0] TIMER_FINAL = 6'h34;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    typedef struct packed {
        logic [5:0] timer;
        logic [3:0] raised;
        logic [4:0] uncharged;
    } bsic_status_t;
endpackage

// [hdl/bsic_hs_channel.sv]
// one high-side bootstrap init channel: charge tracking and link indication
`timescale 1ns/1ns
`default_nettype none
module bsic_hs_channel (
    input wire logic clk_i,             // system clock
    input wire logic reset_i,           // sync reset, high
    input wire logic [6:0] link_sel_i,  // linked low-sides
    input wire logic link_override_i,   // forces indication high
    input wire logic [6:0] ls_on_i,     // synced low-side on states
    input wire logic charged_det_i,     // synced charge detection
    input wire logic timer_done_i,      // timer reached final code
    output logic lowside_active_o,      // low-side active indication
    output logic uncharged_o,           // 1 until charged or low-side active
    output logic raised_o               // higher threshold was used
);
    logic uncharged_reg;
    logic uncharged_next;
    logic raised_reg;
    logic raised_next;

    // R11 linked low-side on
    // R12 override forces high
    assign lowside_active_o = link_override_i | (|(link_sel_i & ls_on_i));

    always_comb begin
        uncharged_next = uncharged_reg;
        raised_next = raised_reg;
        if (uncharged_reg) begin
            // R15 raise threshold at end-of-count
            if (timer_done_i) begin
                raised_next = 1'b1;
            end
            // R2 clear when charged
            // R16 low-side active ends init
            if (charged_det_i || lowside_active_o) begin
                uncharged_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        // R17 reset state
        if (reset_i) begin
            uncharged_reg <= 1'b1;
            raised_reg <= 1'b0;
        end else begin
            uncharged_reg <= uncharged_next;
            raised_reg <= raised_next;
        end
    end

    // R3 raised flag
    assign uncharged_o = uncharged_reg;
    assign raised_o = raised_reg;
endmodule
`default_nettype wire

// [hdl/bsic_top.sv]
// top: bootstrap init status register, coupling registers and global timer
//
// Overview of operation
// R1 - read-only status: timer, raised, charge flags
// R2 - charge flag reads 0 once charged
// R3 - raised flag set if higher threshold used
// R4 - timer field shows six timer MSBs
// R5 - flag pairs encode charge and threshold history
// R6 - timer reads zero during supply undervoltage
// R7 - timer counts up once supply stable
// R8 - timer stops at final code 110100
// R9 - pair A register: high-sides one, two
// R10 - pair B register: high-sides three, four
// R11 - indication high when linked low-side on
// R12 - override bit forces indication high
// R13 - software links only low-sides sharing load
// R14 - one global timer starts leaving undervoltage
// R15 - end-of-count raises threshold for initializing
// R16 - low-side active indication ends initialization
// R17 - defined reset state for flags, links
// R18 - status writes ignored, reads side-effect free
`timescale 1ns/1ns
`default_nettype none
module bsic_top (
    input wire logic clk_i,                  // system clock, 100 MHz
    input wire logic reset_i,                // sync reset, high
    input wire logic [9:0] reg_addr_i,       // register address
    input wire logic reg_wr_i,               // write strobe
    input wire logic reg_rd_i,               // read strobe
    input wire logic [15:0] reg_wdata_i,     // write data
    output logic [15:0] reg_rdata_o,         // read data, registered
    input wire logic supply_uv_i,            // gate supply undervoltage pin
    input wire logic [3:0] charged_det_i,    // per high-side charge detect pin
    input wire logic [6:0] ls_on_i,          // low-side on states pin
    output logic [3:0] lowside_active_o,     // per high-side indication
    output logic [3:0] raised_threshold_o    // per high-side higher threshold
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [11:0] sync1_reg;
    logic [11:0] sync2_reg;
    logic [11:0] sync1_next;
    logic [11:0] sync2_next;
    logic uv_s;
    logic [3:0] det_s;
    logic [6:0] ls_s;

    always_comb begin
        sync1_next = {supply_uv_i, charged_det_i, ls_on_i};
        sync2_next = sync1_reg;
    end

    // undervoltage stage resets high so the timer cannot run before the pin is seen
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_reg <= 12'h800;
            sync2_reg <= 12'h800;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    assign uv_s = sync2_reg[11];
    assign det_s = sync2_reg[10:7];
    assign ls_s = sync2_reg[6:0];

    // ----------------------------------------------------------------
    // global init timer
    // ----------------------------------------------------------------
    logic [5:0] timer_reg;
    logic [5:0] timer_next;
    logic [31:0] step_reg;
    logic [31:0] step_next;
    logic timer_done;

    // the step count restarts with the field, so a supply dip restarts the whole count from code zero
    always_comb begin
        timer_next = timer_reg;
        step_next = step_reg;
        // R6 zero while undervoltage
        if (uv_s) begin
            timer_next = bsic_pkg::TIMER_IDLE;
            step_next = 32'h0000_0000;
        // R8 hold at final code
        end else if (timer_reg != bsic_pkg::TIMER_FINAL) begin
            // R14 global timer on system clock
            // R7 count up while stable
            if (step_reg == 32'(bsic_pkg::CODE_STEP_CYCLES - 1)) begin
                step_next = 32'h0000_0000;
                timer_next = timer_reg + 6'h01;
            end else begin
                step_next = step_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            timer_reg <= bsic_pkg::TIMER_IDLE;
            step_reg <= 32'h0000_0000;
        end else begin
            timer_reg <= timer_next;
            step_reg <= step_next;
        end
    end

    // held at final code, so end-of-count stays true until the supply drops
    assign timer_done = (timer_reg == bsic_pkg::TIMER_FINAL);

    // ----------------------------------------------------------------
    // coupling registers
    // ----------------------------------------------------------------
    logic [15:0] link_a_reg;
    logic [15:0] link_a_next;
    logic [15:0] link_b_reg;
    logic [15:0] link_b_next;

    // writes to the status or an unmapped address fall through and change nothing
    always_comb begin
        link_a_next = link_a_reg;
        link_b_next = link_b_reg;
        if (reg_wr_i) begin
            // R9 pair A layout
            if (reg_addr_i == bsic_pkg::ADDR_LINK_PAIR_A) begin
                link_a_next = reg_wdata_i;
            end
            // R10 pair B layout
            if (reg_addr_i == bsic_pkg::ADDR_LINK_PAIR_B) begin
                link_b_next = reg_wdata_i;
            end
            // R18 status writes dropped
        end
    end

    always_ff @(posedge clk_i) begin
        // R17 links all set at reset
        if (reset_i) begin
            link_a_reg <= bsic_pkg::RESET_LINK_PAIR;
            link_b_reg <= bsic_pkg::RESET_LINK_PAIR;
        end else begin
            link_a_reg <= link_a_next;
            link_b_reg <= link_b_next;
        end
    end

    // ----------------------------------------------------------------
    // per high-side channels
    // ----------------------------------------------------------------
    logic [31:0] links_all;
    logic [3:0] uncharged;
    logic [3:0] raised;

    // channel g takes byte g of the link registers: selects low, override on top
    assign links_all = {link_b_reg, link_a_reg};

    genvar g;
    generate
        for (g = 0; g < bsic_pkg::NUM_HS; g++) begin : g_hs
            bsic_hs_channel u_ch (
                .clk_i(clk_i),
                .reset_i(reset_i),
                .link_sel_i(links_all[g*8 +: 7]),
                .link_override_i(links_all[g*8 + bsic_pkg::OVERRIDE_BIT]),
                .ls_on_i(ls_s),
                .charged_det_i(det_s[g]),
                .timer_done_i(timer_done),
                .lowside_active_o(lowside_active_o[g]),
                .uncharged_o(uncharged[g]),
                .raised_o(raised[g])
            );
        end
    endgenerate

    // raised flags also leave the block for the threshold selection outside it
    assign raised_threshold_o = raised;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    bsic_pkg::bsic_status_t status;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [15:0] status_word;

    // R1 status layout
    // R4 live timer MSBs
    // R5 flag pairs from channel state
    always_comb begin
        status.timer = timer_reg;
        status.raised = raised;
        // fifth high-side is not built here: its flag reads not charged
        status.uncharged = {1'b1, uncharged};
        // spare bit 9 between the timer and the raised flags reads zero
        status_word = {status.timer, 1'b0, status.raised, status.uncharged};
    end

    always_comb begin
        rdata_next = rdata_reg;
        // R18 reads have no side effects
        if (reg_rd_i) begin
            case (reg_addr_i)
                bsic_pkg::ADDR_CHARGE_STATUS: rdata_next = status_word;
                bsic_pkg::ADDR_LINK_PAIR_A: rdata_next = link_a_reg;
                bsic_pkg::ADDR_LINK_PAIR_B: rdata_next = link_b_reg;
                default: rdata_next = bsic_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_reg <= bsic_pkg::READ_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
endmodule
`default_nettype wire

// [test/bsic_top_monitor.sv]
// checker: port-level assertions for the bootstrap init register block
`timescale 1ns/1ns
`default_nettype none
module bsic_top_monitor (
    input wire logic clk_i, // clock
    input wire logic reset_i, // sync reset
    input wire logic [9:0] reg_addr_i, // address
    input wire logic reg_wr_i, // write strobe
    input wire logic reg_rd_i, // read strobe
    input wire logic [15:0] reg_wdata_i, // write data
    input wire logic [15:0] reg_rdata_o, // read data
    input wire logic supply_uv_i, // undervoltage
    input wire logic [6:0] ls_on_i, // low-side states
    input wire logic [3:0] lowside_active_o // indications
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // shadows of high-side one link settings, updated on the same edge as the block
    logic full_reg;
    logic full_next;
    logic ovr_reg;
    logic ovr_next;
    logic mapped;
    logic wr_a;
    assign mapped = reg_addr_i inside {10'h1A5, 10'h1A6, 10'h1A7};
    assign wr_a = reg_wr_i && reg_addr_i == bsic_pkg::ADDR_LINK_PAIR_A;
    always_comb begin
        full_next = wr_a ? reg_wdata_i[6:0] == 7'h7F : full_reg;
        ovr_next = wr_a ? reg_wdata_i[7] : ovr_reg;
    end
    always_ff @(posedge clk_i) begin
        full_reg <= reset_i ? 1'b1 : full_next;
        ovr_reg <= reset_i ? 1'b0 : ovr_next;
    end
    sequence status_read;
        reg_rd_i && reg_addr_i == bsic_pkg::ADDR_CHARGE_STATUS;
    endsequence
    sequence link_write;
        reg_wr_i && reg_addr_i inside {10'h1A6, 10'h1A7};
    endsequence
    // -----------------------------------------
    // assertions
    // -----------------------------------------
    chk_unmapped_zero:
        assert property (reg_rd_i && !mapped |=> reg_rdata_o == 16'h0000) else $error("bad unmapped read");
    chk_rdata_hold:
        assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    chk_timer_uv:
        assert property (supply_uv_i[*6] ##0 status_read |=> reg_rdata_o[15:10] == 6'h00)
        else $error("timer nonzero in undervoltage");
    chk_status_spare:
        assert property (status_read |=> !reg_rdata_o[9] && reg_rdata_o[4]) else $error("bad spare bits");
    chk_timer_cap:
        assert property (status_read |=> reg_rdata_o[15:10] <= 6'h34)
        else $error("timer field beyond final code");
    chk_link_readback:
        assert property (link_write ##2 (reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i, 2))
            |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("link readback wrong");
    chk_override_high:
        assert property (wr_a && reg_wdata_i[15] |=> lowside_active_o[1]) else $error("override ignored");
    chk_link_active:
        assert property ((ls_on_i != 7'h00)[*4] ##0 full_reg |-> lowside_active_o[0])
        else $error("linked low-side not seen");
    chk_link_idle:
        assert property ((ls_on_i == 7'h00)[*4] ##0 !ovr_reg |-> !lowside_active_o[0])
        else $error("indication without cause");
endmodule
`default_nettype wire

// [test/tb_bsic_top.sv]
// testbench: register access, link indication, charge flags and timer start
`timescale 1ns/1ns
`default_nettype none
module tb_bsic_top;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [9:0] reg_addr_i = 10'h000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    logic supply_uv_i = 1'b1;
    logic [3:0] charged_det_i = 4'h0;
    logic [6:0] ls_on_i = 7'h00;
    logic [3:0] lowside_active_o;
    logic [3:0] raised_threshold_o;
    int miscompares = 0;
    int n_tests = 0;
    bsic_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .supply_uv_i(supply_uv_i), .charged_det_i(charged_det_i),
        .ls_on_i(ls_on_i), .lowside_active_o(lowside_active_o),
        .raised_threshold_o(raised_threshold_o));
    always #5 clk_i = ~clk_i;
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        cmp(reg_rdata_o, exp);
    endtask
    // low-side inputs pass a two-stage sync, so allow four edges before looking
    task automatic act(input logic [6:0] ls, input logic [3:0] exp);
        ls_on_i <= ls;
        repeat (4) @(posedge clk_i);
        cmp({12'h000, lowside_active_o}, {12'h000, exp});
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // -----------------------------------------
    // scenarios
    // -----------------------------------------
    task automatic t_reset();
        rd(bsic_pkg::ADDR_CHARGE_STATUS, bsic_pkg::RESET_CHARGE_STATUS);
        rd(bsic_pkg::ADDR_LINK_PAIR_A, bsic_pkg::RESET_LINK_PAIR);
        rd(bsic_pkg::ADDR_LINK_PAIR_B, bsic_pkg::RESET_LINK_PAIR);
        rd(10'h000, bsic_pkg::READ_ZERO);
        wr(bsic_pkg::ADDR_CHARGE_STATUS, 16'hFFFF);
        rd(bsic_pkg::ADDR_CHARGE_STATUS, bsic_pkg::RESET_CHARGE_STATUS);
    endtask
    task automatic t_charge();
        charged_det_i <= 4'h1;
        repeat (4) @(posedge clk_i);
        rd(bsic_pkg::ADDR_CHARGE_STATUS, 16'h001E);
        cmp({12'h000, raised_threshold_o}, 16'h0000);
    endtask
    task automatic t_link();
        wr(bsic_pkg::ADDR_LINK_PAIR_A, 16'h8002);
        rd(bsic_pkg::ADDR_LINK_PAIR_A, 16'h8002);
        wr(bsic_pkg::ADDR_LINK_PAIR_B, 16'h4000);
        rd(bsic_pkg::ADDR_LINK_PAIR_B, 16'h4000);
        act(7'h00, 4'h2);
        act(7'h02, 4'h3);
        act(7'h40, 4'hA);
        rd(bsic_pkg::ADDR_CHARGE_STATUS, 16'h0014);
        wr(bsic_pkg::ADDR_LINK_PAIR_A, 16'h007F);
        act(7'h01, 4'h1);
    endtask
    // only the first timer step fits in the run; the final code lies beyond its length
    task automatic t_timer();
        supply_uv_i <= 1'b0;
        repeat (67990) @(posedge clk_i);
        rd(bsic_pkg::ADDR_CHARGE_STATUS, 16'h0014);
        repeat (20) @(posedge clk_i);
        rd(bsic_pkg::ADDR_CHARGE_STATUS, 16'h0414);
        cmp({12'h000, raised_threshold_o}, 16'h0000);
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_charge();
        t_link();
        t_timer();
        tally_and_finish();
    end
    initial begin
        repeat (80000) @(posedge clk_i);
        miscompares++;
        tally_and_finish();
    end
endmodule
bind bsic_top bsic_top_monitor mon_u (.clk_i(clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .supply_uv_i(supply_uv_i),
    .ls_on_i(ls_on_i), .lowside_active_o(lowside_active_o));
`default_nettype wire
